// File: src/uart_config_status_baud.sv
// Mode, error status and baud selection logic of the asynchronous serial port.
// Assumes a CPU register port and a receive/transmit shifter outside the block.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Mode bit 7 enables transmitter.
// - Mode bit 6 enables receiver.
// - Bits 5:4 select none, zero, odd, even parity.
// - Bit 3 selects seven or eight data bits.
// - Bit 2 selects one or two stop bits.
// - Receiver checks only one stop bit.
// - All four registers reset to zero.
// - Status read-only: parity, framing, overrun flags.
// - Odd or even parity mismatch sets parity error flag.
// - Missing stop bit sets framing error flag.
// - Unread buffer on new frame sets overrun.
// - Overrun repeats until buffer is read.
// - Prescale field picks tap or external pin.
// - Internal rate is clock over 2^(n+1)*16.
// - Prescale field sits in upper nibble.
// - External rate is pin frequency over 16.
// - Seven-bit mode drops and zeroes bit 7.
// - Buffer read clears flags; next frame replaces them.
module uart_config_status_baud
  import uart_cfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       external_baud_clock_pin_i,
  input  wire rx_frame_t  rx_frame_i,
  input  wire logic       rx_done_i,
  input  wire logic [7:0] tx_char_i,
  input  wire logic       tx_load_i,
  output logic            tx_enable_o,
  output logic            rx_enable_o,
  output logic      [7:0] tx_char_o,
  output logic            tx_parity_on_o,
  output logic            tx_parity_bit_o,
  output logic      [1:0] tx_stop_bits_o,
  output logic      [3:0] data_bits_o,
  output logic            rx_parity_on_o,
  output logic      [1:0] rx_stop_bits_o,
  output logic            rx_complete_o,
  output logic            baud_clk_o,
  output logic            bit_tick_o
);

  // ==========================================================================
  // Declarations
  mode_t      mode_q;
  logic [3:0] prescale_q;
  logic       parity_err_q;
  logic       framing_err_q;
  logic       overrun_err_q;
  logic [7:0] rxbuf_q;
  logic       unread_q;
  logic       wr_mode;
  logic       wr_baud;
  logic       rd_rxbuf;
  logic       frame_in;
  logic [7:0] rx_data_eff;
  logic       rx_parity_bad;
  logic [7:0] status_view;
  logic [7:0] mode_view;
  logic [7:0] rdata_d;

  // ==========================================================================
  // Helper functions
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] offs);
    hit = (addr == offs);
  endfunction : hit

  function automatic logic [7:0] char_mask(input logic [7:0] d, input logic long_c);
    char_mask = long_c ? d : {1'b0, d[6:0]};
  endfunction : char_mask

  // ==========================================================================
  // Access decode
  assign wr_mode  = reg_wr_i & hit(reg_addr_i, MODE_OFFSET);
  assign wr_baud  = reg_wr_i & hit(reg_addr_i, BAUD_OFFSET);
  assign rd_rxbuf = reg_rd_i & hit(reg_addr_i, RXBUF_OFFSET);
  // Frames finishing while the receiver is stopped leave everything unchanged.
  assign frame_in = rx_done_i & mode_q.rx_enable;

  // ==========================================================================
  // Mode register
  // Mode cleared on reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= mode_t'(MODE_RESET[7:2]);
    end else if (wr_mode) begin
      mode_q.tx_enable <= reg_wdata_i[TX_ENABLE_POS];
      mode_q.rx_enable <= reg_wdata_i[RX_ENABLE_POS];
      mode_q.parity    <= parity_mode_t'(reg_wdata_i[PARITY_HI_POS:PARITY_LO_POS]);
      mode_q.char_long <= reg_wdata_i[CHAR_LEN_POS];
      mode_q.stop_long <= reg_wdata_i[STOP_LEN_POS];
    end
  end

  // ==========================================================================
  // Baud control register
  // Upper nibble only.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prescale_q <= BAUD_RESET[PRESCALE_HI_POS:PRESCALE_LO_POS];
    end else if (wr_baud) begin
      prescale_q <= reg_wdata_i[PRESCALE_HI_POS:PRESCALE_LO_POS];
    end
  end

  // ==========================================================================
  // Receive parity check
  assign rx_data_eff = char_mask(rx_frame_i.data, mode_q.char_long);

  always_comb begin
    unique case (mode_q.parity)
      PARITY_NONE: rx_parity_bad = 1'b0;
      PARITY_ZERO: rx_parity_bad = 1'b0;
      PARITY_ODD:  rx_parity_bad = ~(^{rx_data_eff, rx_frame_i.parity});
      PARITY_EVEN: rx_parity_bad = ^{rx_data_eff, rx_frame_i.parity};
    endcase
  end

  // ==========================================================================
  // Error flags
  // New frame replaces flags.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      parity_err_q  <= STATUS_RESET[PARITY_ERR_POS];
      framing_err_q <= STATUS_RESET[FRAMING_ERR_POS];
      overrun_err_q <= STATUS_RESET[OVERRUN_ERR_POS];
    end else if (frame_in) begin
      parity_err_q  <= rx_parity_bad;
      framing_err_q <= ~rx_frame_i.stop;
      overrun_err_q <= unread_q & ~rd_rxbuf;
    end else if (rd_rxbuf) begin
      parity_err_q  <= 1'b0;
      framing_err_q <= 1'b0;
      overrun_err_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive buffer
  // Bit 7 forced zero in seven-bit mode.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxbuf_q <= RXBUF_RESET;
    end else if (frame_in) begin
      rxbuf_q <= rx_data_eff;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unread_q <= 1'b0;
    end else if (frame_in) begin
      unread_q <= 1'b1;
    end else if (rd_rxbuf) begin
      unread_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_complete_o <= 1'b0;
    end else begin
      rx_complete_o <= frame_in;
    end
  end

  // ==========================================================================
  // Register read port
  // Upper status bits zero.
  assign status_view = {5'h00, parity_err_q, framing_err_q, overrun_err_q};
  assign mode_view   = {mode_q, 2'b00};

  always_comb begin
    rdata_d = 8'h00;
    if (hit(reg_addr_i, MODE_OFFSET)) begin
      rdata_d = mode_view;
    end else if (hit(reg_addr_i, STATUS_OFFSET)) begin
      rdata_d = status_view;
    end else if (hit(reg_addr_i, BAUD_OFFSET)) begin
      rdata_d = {prescale_q, 4'h0};
    end else if (hit(reg_addr_i, RXBUF_OFFSET)) begin
      rdata_d = rxbuf_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // ==========================================================================
  // Transmit side configuration
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_char_o       <= 8'h00;
      tx_parity_bit_o <= 1'b0;
    end else if (tx_load_i && mode_q.tx_enable) begin
      tx_char_o <= char_mask(tx_char_i, mode_q.char_long);
      unique case (mode_q.parity)
        PARITY_NONE: tx_parity_bit_o <= 1'b0;
        PARITY_ZERO: tx_parity_bit_o <= 1'b0;
        PARITY_ODD:  tx_parity_bit_o <= ~(^char_mask(tx_char_i, mode_q.char_long));
        PARITY_EVEN: tx_parity_bit_o <= ^char_mask(tx_char_i, mode_q.char_long);
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_enable_o    <= 1'b0;
      rx_enable_o    <= 1'b0;
      tx_parity_on_o <= 1'b0;
      rx_parity_on_o <= 1'b0;
      tx_stop_bits_o <= RX_STOP_CHECKED;
      rx_stop_bits_o <= RX_STOP_CHECKED;
      data_bits_o    <= DATA_BITS_SHORT;
    end else begin
      tx_enable_o    <= mode_q.tx_enable;
      rx_enable_o    <= mode_q.rx_enable;
      tx_parity_on_o <= (mode_q.parity != PARITY_NONE);
      rx_parity_on_o <= (mode_q.parity != PARITY_NONE);
      tx_stop_bits_o <= mode_q.stop_long ? 2'h2 : 2'h1;
      rx_stop_bits_o <= RX_STOP_CHECKED;
      data_bits_o    <= mode_q.char_long ? DATA_BITS_LONG : DATA_BITS_SHORT;
    end
  end

  // ==========================================================================
  // Baud clock
  // Runs while enabled.
  baud_clock_gen u_baud (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .sel_i      (prescale_q),
    .run_i      (mode_q.tx_enable | mode_q.rx_enable),
    .ext_pin_i  (external_baud_clock_pin_i),
    .baud_clk_o (baud_clk_o),
    .bit_tick_o (bit_tick_o)
  );

endmodule : uart_config_status_baud

`default_nettype wire

// File: src/uart_cfg_pkg.sv
// Package of shared constants and types for the serial port control block.
// Assumes an 8-bit CPU register port with 16-bit addresses.
package uart_cfg_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] MODE_OFFSET   = 16'hFF70;
  localparam logic [15:0] STATUS_OFFSET = 16'hFF71;
  localparam logic [15:0] BAUD_OFFSET   = 16'hFF73;
  localparam logic [15:0] RXBUF_OFFSET  = 16'hFF74;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET   = 8'h00;
  localparam logic [7:0] RXBUF_RESET  = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int TX_ENABLE_POS   = 7;
  localparam int RX_ENABLE_POS   = 6;
  localparam int PARITY_HI_POS   = 5;
  localparam int PARITY_LO_POS   = 4;
  localparam int CHAR_LEN_POS    = 3;
  localparam int STOP_LEN_POS    = 2;
  localparam int PARITY_ERR_POS  = 2;
  localparam int FRAMING_ERR_POS = 1;
  localparam int OVERRUN_ERR_POS = 0;
  localparam int PRESCALE_HI_POS = 7;
  localparam int PRESCALE_LO_POS = 4;

  // ==========================================================================
  // Baud generation and frame format constants
  localparam logic [3:0] PRESCALE_EXTERNAL = 4'h8;
  localparam logic [3:0] PRESCALE_LAST_INT = 4'h7;
  localparam logic [2:0] BAUD_COUNT_LAST   = 3'h7;
  localparam logic [1:0] RX_STOP_CHECKED   = 2'h1;
  localparam logic [3:0] DATA_BITS_SHORT   = 4'h7;
  localparam logic [3:0] DATA_BITS_LONG    = 4'h8;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PARITY_NONE = 2'b00,
    PARITY_ZERO = 2'b01,
    PARITY_ODD  = 2'b10,
    PARITY_EVEN = 2'b11
  } parity_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
    logic       stop;
  } rx_frame_t;

  typedef struct packed {
    logic         tx_enable;
    logic         rx_enable;
    parity_mode_t parity;
    logic         char_long;
    logic         stop_long;
  } mode_t;

endpackage : uart_cfg_pkg

// File: src/baud_clock_gen.sv
// Baud clock generator: prescaler tap or external pin feeding a 3-bit counter.
// Assumes the external pin is already synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module baud_clock_gen
  import uart_cfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [3:0] sel_i,
  input  wire logic       run_i,
  input  wire logic       ext_pin_i,
  output logic            baud_clk_o,
  output logic            bit_tick_o
);

  logic [7:0] pre_q;
  logic       pin_q;
  logic [2:0] cnt_q;
  logic [7:0] tap_mask;
  logic       tick;

  // ==========================================================================
  // Prescaler taps
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      pre_q <= run_i ? pre_q + 8'h01 : 8'h00;
      pin_q <= ext_pin_i;
    end
  end

  always_comb begin
    tap_mask = 8'(({1'b0, 8'h01} << ({1'b0, sel_i[2:0]} + 4'h1)) - 9'h001);
    if (!run_i) begin
      tick = 1'b0;
    end else if (sel_i == PRESCALE_EXTERNAL) begin
      tick = ext_pin_i & ~pin_q;
    end else if (sel_i <= PRESCALE_LAST_INT) begin
      tick = &(pre_q | ~tap_mask);
    end else begin
      tick = 1'b0;
    end
  end

  // ==========================================================================
  // Three-bit counter
  // Divide by sixteen.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q      <= 3'h0;
      baud_clk_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q      <= 3'h0;
      baud_clk_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else begin
      bit_tick_o <= 1'b0;
      if (tick) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == BAUD_COUNT_LAST) begin
          baud_clk_o <= ~baud_clk_o;
          bit_tick_o <= baud_clk_o;
        end
      end
    end
  end

endmodule : baud_clock_gen

`default_nettype wire

// File: tb/uart_cfg_checker.sv
// Checker of the serial port control block, watching its ports only.
// Assumes a bind onto uart_config_status_baud and the shared package.
`timescale 1ns/10ps
`default_nettype none

module uart_cfg_checker
  import uart_cfg_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        rx_done_i,
  input wire logic        tx_load_i,
  input wire logic [7:0]  tx_char_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        tx_enable_o,
  input wire logic        rx_enable_o,
  input wire logic [7:0]  tx_char_o,
  input wire logic [3:0]  data_bits_o,
  input wire logic [1:0]  tx_stop_bits_o,
  input wire logic [1:0]  rx_stop_bits_o,
  input wire logic        rx_complete_o,
  input wire logic        bit_tick_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================================
  // Assertions
  logic mode_wr;
  assign mode_wr = reg_wr_i && reg_addr_i == MODE_OFFSET;

  property p_tx_en;
    mode_wr |-> ##2 tx_enable_o == $past(reg_wdata_i[TX_ENABLE_POS], 2);
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("tx enable mismatch");

  property p_rx_done;
    rx_done_i && !$past(reg_wr_i) |=> rx_complete_o == $past(rx_enable_o);
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx completion mismatch");

  property p_len;
    mode_wr |-> ##2 data_bits_o == ($past(reg_wdata_i[CHAR_LEN_POS], 2) ? 4'h8 : 4'h7);
  endproperty
  a_len: assert property (p_len) else $error("data length mismatch");

  property p_stop;
    mode_wr |-> ##2 tx_stop_bits_o == ($past(reg_wdata_i[STOP_LEN_POS], 2) ? 2'h2 : 2'h1);
  endproperty
  a_stop: assert property (p_stop) else $error("stop length mismatch");

  property p_rx_stop;
    rx_stop_bits_o == RX_STOP_CHECKED;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx stop count mismatch");

  property p_sts;
    reg_rd_i && reg_addr_i == STATUS_OFFSET |=> reg_rdata_o[7:3] == 5'h00;
  endproperty
  a_sts: assert property (p_sts) else $error("status upper bits set");

  property p_tick;
    bit_tick_o |=> (!bit_tick_o) [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("bit tick too close");

  property p_char7;
    tx_load_i && tx_enable_o && !$past(reg_wr_i) |=>
      tx_char_o == {$past(tx_char_i[7]) && data_bits_o == 4'h8, $past(tx_char_i[6:0])};
  endproperty
  a_char7: assert property (p_char7) else $error("tx char mismatch");

  property p_clr;
    (reg_rd_i && reg_addr_i == RXBUF_OFFSET && !rx_done_i) ##1 !rx_done_i ##1
      (reg_rd_i && reg_addr_i == STATUS_OFFSET && !rx_done_i) |=> reg_rdata_o == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");

endmodule : uart_cfg_checker

bind uart_config_status_baud uart_cfg_checker uart_cfg_checker_inst (
  .clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .rx_done_i,
  .tx_load_i, .tx_char_i, .reg_rdata_o, .tx_enable_o, .rx_enable_o, .tx_char_o,
  .data_bits_o, .tx_stop_bits_o, .rx_stop_bits_o, .rx_complete_o, .bit_tick_o
);

`default_nettype wire

// File: tb/uart_peer_model.sv
// Remote serial peer: hands over received frames and the external baud clock.
// Assumes the bench calls send_frame from its main process.
`timescale 1ns/10ps
`default_nettype none

module uart_peer_model
  import uart_cfg_pkg::*;
#(
  parameter int PIN_HALF = 3
)
(
  input  wire logic clk_i,
  output rx_frame_t frame_o,
  output logic      done_o,
  output logic      pin_o
);
  int cnt;

  initial begin
    cnt = 0;
    frame_o = '0;
    done_o = 1'b0;
    pin_o = 1'b0;
  end

  // ==========================================================================
  // External baud clock, free running
  // Pin is an output, toggled every PIN_HALF clocks.
  always @(posedge clk_i) begin
    if (cnt == PIN_HALF - 1) begin
      cnt <= 0;
      pin_o <= ~pin_o;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // ==========================================================================
  // Frame delivery; stale data is inverted once the pulse ends
  task automatic send_frame(input logic [7:0] d, input logic p, input logic s);
    @(negedge clk_i);
    frame_o = {d, p, s};
    done_o = 1'b1;
    @(negedge clk_i);
    done_o = 1'b0;
    frame_o = ~frame_o;
  endtask : send_frame

endmodule : uart_peer_model

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench of the serial port control block.
// Assumes the peer model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import uart_cfg_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [15:0] reg_addr_i = '0;
  logic [7:0]  reg_wdata_i = '0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  tx_char_i = '0;
  logic        tx_load_i = 1'b0;
  logic        external_baud_clock_pin_i;
  rx_frame_t   rx_frame_i;
  logic        rx_done_i;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  tx_char_o;
  logic        tx_parity_on_o;
  logic        tx_parity_bit_o;
  logic [1:0]  tx_stop_bits_o;
  logic [1:0]  rx_stop_bits_o;
  logic [3:0]  data_bits_o;
  logic        bit_tick_o;
  logic        rx_enable_o;
  logic        rx_parity_on_o;
  logic        baud_clk_o;
  int          mismatches = 0;
  int          num_checks = 0;

  always #50 clk_i = ~clk_i;

  uart_peer_model uart_peer_model_inst (
    .clk_i, .frame_o(rx_frame_i), .done_o(rx_done_i), .pin_o(external_baud_clock_pin_i)
  );

  uart_config_status_baud uart_config_status_baud_inst (
    .clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .external_baud_clock_pin_i, .rx_frame_i, .rx_done_i, .tx_char_i, .tx_load_i,
    .tx_enable_o(), .rx_enable_o, .tx_char_o, .tx_parity_on_o, .tx_parity_bit_o,
    .tx_stop_bits_o, .data_bits_o, .rx_parity_on_o, .rx_stop_bits_o,
    .rx_complete_o(), .baud_clk_o, .bit_tick_o
  );

  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask : rdc

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (bit_tick_o !== 1'b1 && n < 6000);
    if (n >= 6000) begin
      mismatches++;
      test_done();
    end
  endtask : wait_tick

  task automatic do_reset();
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
  endtask : do_reset

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rdc(MODE_OFFSET, 8'h00);
    rdc(STATUS_OFFSET, 8'h00);
    rdc(BAUD_OFFSET, 8'h00);
    rdc(16'hFF72, 8'h00);
    chk(data_bits_o, 4'h7);
  endtask : t_reset

  task automatic t_mode();
    logic [7:0] m;
    logic [7:0] c;
    for (int p = 0; p < 4; p++) begin
      m = {2'b11, p[1:0], p[0], p[1], 2'b00};
      c = p[0] ? 8'hB5 : 8'h35;
      wr(MODE_OFFSET, 8'h00);
      wr(MODE_OFFSET, m);
      rdc(MODE_OFFSET, m & 8'hFC);
      chk(tx_parity_on_o, p != 0);
      chk(rx_parity_on_o, p != 0);
      chk(rx_enable_o, 1'b1);
      chk(data_bits_o, p[0] ? 4'h8 : 4'h7);
      chk(tx_stop_bits_o, p[1] ? 2'h2 : 2'h1);
      chk(rx_stop_bits_o, 2'h1);
      @(negedge clk_i);
      tx_char_i = 8'hB5;
      tx_load_i = 1'b1;
      @(negedge clk_i);
      tx_load_i = 1'b0;
      chk(tx_char_o, c);
      chk(tx_parity_bit_o, p == 2 ? ~^c : (p == 3 ? ^c : 1'b0));
    end
  endtask : t_mode

  task automatic t_baud();
    int n;
    int cnt;
    for (int k = 1; k < 10; k++) begin
      wr(MODE_OFFSET, 8'h00);
      wr(BAUD_OFFSET, {k[3:0], 4'hF});
      rdc(BAUD_OFFSET, {k[3:0], 4'h0});
      wr(MODE_OFFSET, 8'h80);
      if (k < 9) begin
        wait_tick(n);
        wait_tick(n);
        chk(16'(n), k == 8 ? 16'd96 : 16'(32 << k));
        chk(baud_clk_o, 1'b0);
      end else begin
        cnt = 0;
        repeat (300) begin
          @(negedge clk_i);
          cnt += int'(bit_tick_o === 1'b1);
        end
        chk(16'(cnt), 16'h0000);
      end
    end
    wr(MODE_OFFSET, 8'h00);
  endtask : t_baud

  task automatic t_rx();
    wr(MODE_OFFSET, 8'hE8);
    uart_peer_model_inst.send_frame(8'h0F, 1'b0, 1'b0);
    rdc(STATUS_OFFSET, 8'h06);
    uart_peer_model_inst.send_frame(8'h0F, 1'b1, 1'b1);
    rdc(STATUS_OFFSET, 8'h01);
    uart_peer_model_inst.send_frame(8'h3C, 1'b1, 1'b1);
    rdc(STATUS_OFFSET, 8'h01);
    rdc(RXBUF_OFFSET, 8'h3C);
    rdc(STATUS_OFFSET, 8'h00);
    wr(MODE_OFFSET, 8'h00);
    wr(MODE_OFFSET, 8'hF0);
    uart_peer_model_inst.send_frame(8'h83, 1'b1, 1'b1);
    rdc(STATUS_OFFSET, 8'h04);
    rdc(RXBUF_OFFSET, 8'h03);
    wr(MODE_OFFSET, 8'h00);
    wr(MODE_OFFSET, 8'hD8);
    uart_peer_model_inst.send_frame(8'h01, 1'b1, 1'b1);
    rdc(STATUS_OFFSET, 8'h00);
    wr(MODE_OFFSET, 8'h00);
    wr(MODE_OFFSET, 8'h98);
    uart_peer_model_inst.send_frame(8'hFF, 1'b0, 1'b0);
    rdc(STATUS_OFFSET, 8'h00);
    rdc(RXBUF_OFFSET, 8'h01);
  endtask : t_rx

  initial begin
    do_reset();
    t_reset();
    t_mode();
    t_baud();
    t_rx();
    do_reset();
    t_reset();
    test_done();
  end

endmodule : tb_top

`default_nettype wire
